// ==== src/psv_exit.sv ====
// priority shadow and external interrupt vm exit logic with apb registers
`timescale 1ns/10ps
`default_nettype none
module psv_exit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [3:0] acc_wdata,
  output logic acc_done,
  output logic [3:0] acc_rdata,
  input wire logic ext_int,
  output logic int_ack,
  input wire logic ack_valid,
  input wire logic [7:0] ack_vector,
  output logic vm_exit,
  output logic interrupt_enable_flag,
  output logic [3:0] task_priority
);
  import psv_pkg::*;

  // architectural state
  logic [CTRL_W-1:0] ctrl;
  logic [3:0] thresh;
  logic [ADDR_W-1:PAGE_ALIGN_BITS] page_ptr;
  logic [ADDR_W-1:PAGE_ALIGN_BITS] intc_base;
  logic [7:0] shadow_byte;
  logic [15:0] exit_reason;
  logic [31:0] exit_info;
  logic bad_vector;
  psv_state_t state;
  // next values of the state
  logic [CTRL_W-1:0] next_ctrl;
  logic [3:0] next_thresh;
  logic [ADDR_W-1:PAGE_ALIGN_BITS] next_page_ptr;
  logic [ADDR_W-1:PAGE_ALIGN_BITS] next_intc_base;
  logic [7:0] next_shadow_byte;
  logic [15:0] next_exit_reason;
  logic [31:0] next_exit_info;
  logic next_bad_vector;
  psv_state_t next_state;
  // next values of the registered outputs
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_acc_done;
  logic [3:0] next_acc_rdata;
  logic next_int_ack;
  logic next_vm_exit;
  logic next_if;
  logic [3:0] next_task_priority;
  // synchronised pins, routing and bus strobes
  logic ext_sync;
  logic ack_v_sync;
  logic [7:0] ack_vec_q;
  logic [7:0] ack_vec_qq;
  psv_route_t route;
  logic bus_wr;
  logic bus_rd;

  // register decode, used for read and write
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      OFF_CTRL, OFF_THRESH, OFF_PAGE_LO, OFF_PAGE_HI, OFF_INTC_BASE_LO,
      OFF_INTC_BASE_HI, OFF_PRIO, OFF_EXIT_REASON, OFF_EXIT_INFO,
      OFF_STATUS, OFF_SHADOW_BYTE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  // router for guest priority-register moves
  psv_route u_route (
    .shadow_enable(ctrl[CTRL_SHADOW_EN]),
    .priority_read_exiting(ctrl[CTRL_READ_EXIT]),
    .priority_write_exiting(ctrl[CTRL_WRITE_EXIT]),
    .is_write(acc_write),
    .valid(acc_valid && (state == ST_GUEST)),
    .route(route)
  );

  psv_vecsync u_ext (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(ext_int),
    .dout(ext_sync)
  );

  psv_vecsync u_ackv (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .din(ack_valid),
    .dout(ack_v_sync)
  );

  // vector bus sampled twice alongside its valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_vec_q <= 8'h00;
      ack_vec_qq <= 8'h00;
    end else if (ce) begin
      ack_vec_q <= ack_vector;
      ack_vec_qq <= ack_vec_q;
    end
  end

  // apb strobes, once per transfer
  assign bus_wr = psel && penable && pwrite && !pready;
  assign bus_rd = psel && penable && !pwrite && !pready;

  // next-state for bus, guest accesses and exits
  always_comb begin
    next_ctrl = ctrl;
    next_thresh = thresh;
    next_page_ptr = page_ptr;
    next_intc_base = intc_base;
    next_shadow_byte = shadow_byte;
    next_exit_reason = exit_reason;
    next_exit_info = exit_info;
    next_bad_vector = bad_vector;
    next_state = state;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_acc_done = 1'b0;
    next_acc_rdata = acc_rdata;
    next_int_ack = 1'b0;
    next_vm_exit = 1'b0;
    next_if = interrupt_enable_flag;
    next_task_priority = task_priority;
    // apb slave: one wait state, answer in access cycle 2
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      next_pslverr = !mapped(paddr);
      next_prdata = 32'h0000_0000;
      if (bus_wr) begin
        case (paddr)
          OFF_CTRL: begin
            next_ctrl = pwdata[CTRL_W-1:0];
            if (pwdata[CTRL_IF_SET]) next_if = 1'b1;
          end
          OFF_THRESH: next_thresh = pwdata[3:0];
          OFF_PAGE_LO: next_page_ptr[31:PAGE_ALIGN_BITS] = pwdata[31:PAGE_ALIGN_BITS];
          OFF_PAGE_HI: next_page_ptr[63:32] = pwdata;
          OFF_INTC_BASE_LO: next_intc_base[31:PAGE_ALIGN_BITS] = pwdata[31:PAGE_ALIGN_BITS];
          OFF_INTC_BASE_HI: next_intc_base[63:32] = pwdata;
          OFF_PRIO: next_task_priority = pwdata[3:0];
          OFF_SHADOW_BYTE: next_shadow_byte = pwdata[7:0];
          OFF_STATUS: begin
            if (pwdata[0]) next_state = ST_GUEST;
            if (pwdata[1]) next_bad_vector = 1'b0;
          end
          default: ;
        endcase
      end else if (bus_rd) begin
        case (paddr)
          OFF_CTRL: next_prdata = {26'h000_0000, ctrl};
          OFF_THRESH: next_prdata = {28'h000_0000, thresh};
          OFF_PAGE_LO: next_prdata = {page_ptr[31:PAGE_ALIGN_BITS], 12'h000};
          OFF_PAGE_HI: next_prdata = page_ptr[63:32];
          OFF_INTC_BASE_LO: next_prdata = {intc_base[31:PAGE_ALIGN_BITS], 12'h000};
          OFF_INTC_BASE_HI: next_prdata = intc_base[63:32];
          OFF_PRIO: next_prdata = {28'h000_0000, task_priority};
          OFF_EXIT_REASON: next_prdata = {16'h0000, exit_reason};
          OFF_EXIT_INFO: next_prdata = exit_info;
          OFF_STATUS: next_prdata = {29'h0000_0000, bad_vector, interrupt_enable_flag,
            state == ST_HOST};
          OFF_SHADOW_BYTE: next_prdata = {24'h00_0000, shadow_byte};
          default: next_prdata = 32'h0000_0000;
        endcase
      end
    end
    // guest priority-register accesses
    case (route)
      ACC_SHADOW: begin
        next_acc_done = 1'b1;
        if (acc_write) begin
          next_shadow_byte[7:SHADOW_LSB] = acc_wdata;
          if (acc_wdata < thresh) begin
            next_vm_exit = 1'b1;
            next_exit_reason = REASON_THRESHOLD;
            next_if = 1'b0;
            next_state = ST_HOST;
          end
        end else begin
          next_acc_rdata = shadow_byte[7:SHADOW_LSB];
        end
      end
      ACC_PHYS: begin
        next_acc_done = 1'b1;
        if (acc_write) next_task_priority = acc_wdata;
        else next_acc_rdata = task_priority;
      end
      ACC_EXIT: begin
        next_acc_done = 1'b1;
        next_vm_exit = 1'b1;
        next_exit_reason = REASON_PRIO_ACCESS;
        next_if = 1'b0;
        next_state = ST_HOST;
      end
      default: ;
    endcase
    // external interrupt exit, lower priority than a guest access
    case (state)
      ST_GUEST: begin
        if (route == ACC_NONE && ext_sync && ctrl[CTRL_EXTINT_EXIT]) begin
          next_exit_reason = REASON_EXTINT;
          next_exit_info = 32'h0000_0000;
          if (ctrl[CTRL_ACK_ON_EXIT]) begin
            next_int_ack = 1'b1;
            next_state = ST_ACK;
          end else begin
            next_vm_exit = 1'b1;
            next_if = 1'b0;
            next_state = ST_HOST;
          end
        end
      end
      ST_ACK: begin
        next_int_ack = !ack_v_sync;
        if (ack_v_sync) begin
          next_exit_info = {1'b1, 23'h00_0000, ack_vec_qq};
          next_bad_vector = ack_vec_qq < VEC_MIN_EXT;
          next_vm_exit = 1'b1;
          next_if = 1'b0;
          next_state = ST_HOST;
        end
      end
      ST_HOST: ;
      default: next_state = ST_GUEST;
    endcase
  end

  // registers, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      thresh <= THRESH_RST;
      page_ptr <= '0;
      intc_base <= '0;
      shadow_byte <= SHADOW_RST;
      exit_reason <= REASON_NONE;
      exit_info <= 32'h0000_0000;
      bad_vector <= 1'b0;
      state <= ST_GUEST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      acc_done <= 1'b0;
      acc_rdata <= 4'h0;
      int_ack <= 1'b0;
      vm_exit <= 1'b0;
      interrupt_enable_flag <= 1'b0;
      task_priority <= PRIO_RST;
    end else if (ce) begin
      ctrl <= next_ctrl;
      thresh <= next_thresh;
      page_ptr <= next_page_ptr;
      intc_base <= next_intc_base;
      shadow_byte <= next_shadow_byte;
      exit_reason <= next_exit_reason;
      exit_info <= next_exit_info;
      bad_vector <= next_bad_vector;
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      acc_done <= next_acc_done;
      acc_rdata <= next_acc_rdata;
      int_ack <= next_int_ack;
      vm_exit <= next_vm_exit;
      interrupt_enable_flag <= next_if;
      task_priority <= next_task_priority;
    end
  end
endmodule : psv_exit
`default_nettype wire

// ==== src/psv_pkg.sv ====
// package: register map, field layout and codes for the priority shadow exit block
package psv_pkg;
  // apb register byte offsets (one aligned word each)
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_THRESH = 12'h004;
  localparam logic [11:0] OFF_PAGE_LO = 12'h008;
  localparam logic [11:0] OFF_PAGE_HI = 12'h00C;
  localparam logic [11:0] OFF_INTC_BASE_LO = 12'h010;
  localparam logic [11:0] OFF_INTC_BASE_HI = 12'h014;
  localparam logic [11:0] OFF_PRIO = 12'h018;
  localparam logic [11:0] OFF_EXIT_REASON = 12'h01C;
  localparam logic [11:0] OFF_EXIT_INFO = 12'h020;
  localparam logic [11:0] OFF_STATUS = 12'h024;
  localparam logic [11:0] OFF_SHADOW_BYTE = 12'h080;
  // control register bit positions
  localparam int CTRL_SHADOW_EN = 0;
  localparam int CTRL_READ_EXIT = 1;
  localparam int CTRL_WRITE_EXIT = 2;
  localparam int CTRL_EXTINT_EXIT = 3;
  localparam int CTRL_ACK_ON_EXIT = 4;
  localparam int CTRL_IF_SET = 5;
  localparam int CTRL_W = 6;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [3:0] THRESH_RST = 4'h0;
  localparam logic [7:0] SHADOW_RST = 8'h00;
  localparam logic [3:0] PRIO_RST = 4'h0;
  // page geometry: 4 kbyte aligned page
  localparam int PAGE_ALIGN_BITS = 12;
  localparam int ADDR_W = 64;
  // shadow nibble sits in bits 7:4 of the byte at 80h
  localparam int SHADOW_LSB = 4;
  // exit reason codes
  localparam logic [15:0] REASON_NONE = 16'h0000;
  localparam logic [15:0] REASON_EXTINT = 16'h0001;
  localparam logic [15:0] REASON_PRIO_ACCESS = 16'h001C;
  localparam logic [15:0] REASON_THRESHOLD = 16'h002B;
  // lowest vector open to external interrupts
  localparam logic [7:0] VEC_MIN_EXT = 8'h20;
  // interruption info valid bit
  localparam int INFO_VALID = 31;
  typedef enum logic [1:0] {
    ACC_NONE,
    ACC_SHADOW,
    ACC_PHYS,
    ACC_EXIT
  } psv_route_t;
  typedef enum {
    ST_GUEST,
    ST_ACK,
    ST_HOST
  } psv_state_t;
endpackage : psv_pkg

// ==== src/psv_route.sv ====
// decoder choosing how a guest priority-register access is routed
`timescale 1ns/10ps
`default_nettype none
module psv_route (
  input wire logic shadow_enable,
  input wire logic priority_read_exiting,
  input wire logic priority_write_exiting,
  input wire logic is_write,
  input wire logic valid,
  output psv_pkg::psv_route_t route
);
  import psv_pkg::*;
  // exiting controls override shadowing
  always_comb begin
    if (!valid) begin
      route = ACC_NONE;
    end else if (is_write && priority_write_exiting) begin
      route = ACC_EXIT;
    end else if (!is_write && priority_read_exiting) begin
      route = ACC_EXIT;
    end else if (shadow_enable) begin
      route = ACC_SHADOW;
    end else begin
      route = ACC_PHYS;
    end
  end
endmodule : psv_route
`default_nettype wire

// ==== src/psv_vecsync.sv ====
// two-flop synchroniser for the external interrupt and acknowledge valid pins
`timescale 1ns/10ps
`default_nettype none
module psv_vecsync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic din,
  output logic dout
);
  import psv_pkg::*;
  logic meta;
  logic next_meta;
  logic next_dout;
  // sample chain
  always_comb begin
    next_meta = ce ? din : meta;
    next_dout = ce ? meta : dout;
  end
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule : psv_vecsync
`default_nettype wire

// ==== testbench/psv_intc_model.sv ====
// platform interrupt controller model answering the acknowledge
`timescale 1ns/10ps
`default_nettype none
module psv_intc_model #(
  parameter int WAIT = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] host_vector,
  input wire logic int_ack,
  output logic ack_valid,
  output logic [7:0] ack_vector
);
  int dly;
  // vector offered after a delay, held until the acknowledge drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly <= 0;
      ack_valid <= 1'b0;
    end else begin
      dly <= int_ack ? dly + 1 : 0;
      ack_valid <= int_ack && (ack_valid || dly >= WAIT);
    end
  end
  // no stale vector once released
  assign ack_vector = ack_valid ? host_vector : ~host_vector;
endmodule : psv_intc_model
`default_nettype wire

// ==== testbench/psv_exit_chk.sv ====
// checker for guest access routing, exits and the interrupt flag
`timescale 1ns/10ps
`default_nettype none
module psv_exit_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [3:0] acc_wdata,
  input wire logic acc_done,
  input wire logic int_ack,
  input wire logic vm_exit,
  input wire logic interrupt_enable_flag,
  input wire logic [3:0] task_priority
);
  import psv_pkg::*;
  logic wr;
  logic [CTRL_W-1:0] ctrl;
  logic [CTRL_W-1:0] next_ctrl;
  logic [3:0] thr;
  logic [3:0] next_thr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mirror of control bits and threshold
  always_comb begin
    wr = psel && penable && pready && pwrite;
    next_ctrl = (wr && paddr == OFF_CTRL) ? pwdata[CTRL_W-1:0] : ctrl;
    next_thr = (wr && paddr == OFF_THRESH) ? pwdata[3:0] : thr;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      thr <= THRESH_RST;
    end else begin
      ctrl <= next_ctrl;
      thr <= next_thr;
    end
  end
  a_exit_if_clear: assert property (vm_exit |-> !interrupt_enable_flag)
    else $error("flag set on exit");
  a_if_set_cause: assert property ($rose(interrupt_enable_flag) |-> wr
    && paddr == OFF_CTRL && pwdata[CTRL_IF_SET]) else $error("flag set without write");
  a_write_exit: assert property (acc_done && $past(acc_valid && acc_write
    && ctrl[CTRL_WRITE_EXIT]) |-> vm_exit) else $error("write did not exit");
  a_read_exit: assert property (acc_done && $past(acc_valid && !acc_write
    && ctrl[CTRL_READ_EXIT]) |-> vm_exit) else $error("read did not exit");
  a_phys_write: assert property (acc_done && $past(acc_valid && acc_write
    && ctrl[2:0] == 3'b000) |-> task_priority == $past(acc_wdata) && !vm_exit)
    else $error("physical write wrong");
  a_shadow_keeps: assert property (acc_done && $past(acc_valid && acc_write
    && ctrl[2:0] == 3'b001) |-> $stable(task_priority)) else $error("priority hit");
  a_thresh_exit: assert property (acc_done && $past(acc_valid && acc_write
    && ctrl[2:0] == 3'b001) |-> vm_exit == $past(acc_wdata < thr))
    else $error("threshold exit wrong");
  a_ext_exit: assert property (vm_exit && !acc_done |-> ctrl[CTRL_EXTINT_EXIT])
    else $error("exit without cause");
  a_ack_cause: assert property ($rose(int_ack) |-> $past(ctrl[CTRL_ACK_ON_EXIT]))
    else $error("acknowledge not enabled");
  a_ack_exit: assert property ($fell(int_ack) |-> ##[0:3] vm_exit)
    else $error("no exit after acknowledge");
endmodule : psv_exit_chk
bind psv_exit psv_exit_chk psv_exit_chk_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .acc_valid,
  .acc_write, .acc_wdata, .acc_done, .int_ack, .vm_exit, .interrupt_enable_flag,
  .task_priority
);
`default_nettype wire

// ==== testbench/test_priority_shadow_vm_exit_logic.sv ====
// bench: apb and guest accesses against the exit block
`timescale 1ns/10ps
`default_nettype none
module test_priority_shadow_vm_exit_logic;
  import psv_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic acc_valid = 1'b0, acc_write = 1'b0, ext_int = 1'b0, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] acc_wdata = 4'h0, acc_rdata, task_priority;
  logic pready, pslverr, acc_done, int_ack, ack_valid, vm_exit, interrupt_enable_flag;
  logic [7:0] ack_vector;
  logic [7:0] host_vector = 8'h45;
  logic ce = 1'b1;
  int fail_count = 0, n_tests = 0;
  always #10 pclk = ~pclk;
  psv_exit psv_exit_inst (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .acc_valid, .acc_write, .acc_wdata, .acc_done, .acc_rdata,
    .ext_int, .int_ack, .ack_valid, .ack_vector, .vm_exit, .interrupt_enable_flag,
    .task_priority
  );
  psv_intc_model psv_intc_model_inst (.pclk, .presetn, .host_vector, .int_ack, .ack_valid,
    .ack_vector);
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one guest access of one cycle
  task automatic guest(input logic w, input logic [3:0] d, input logic x);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_write <= w;
    acc_wdata <= d;
    @(posedge pclk);
    acc_valid <= 1'b0;
    #1;
    chk("done", 32'(acc_done), 32'h1);
    chk("exit", 32'(vm_exit), 32'(x));
  endtask : guest
  // external interrupt until the exit shows
  task automatic ext_exit(input logic [31:0] ctl);
    apb(1'b1, OFF_CTRL, ctl);
    ext_int <= 1'b1;
    do @(posedge pclk); while (vm_exit !== 1'b1);
    chk("flag", 32'(interrupt_enable_flag), 32'h0);
    ext_int <= 1'b0;
    apb(1'b0, OFF_EXIT_REASON, 32'h0);
    chk("reason", rd, 32'(REASON_EXTINT));
  endtask : ext_exit
  // verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  // test sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_SHADOW_BYTE, 32'h0);
    chk("shadow", rd, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    chk("slverr", 32'(er), 32'h1);
    $display("reset test done");
    guest(1'b1, 4'h5, 1'b0);
    chk("prio", 32'(task_priority), 32'h5);
    guest(1'b0, 4'h0, 1'b0);
    chk("rdata", 32'(acc_rdata), 32'h5);
    apb(1'b1, OFF_THRESH, 32'hFFFF_FFF3);
    apb(1'b0, OFF_THRESH, 32'h0);
    chk("thresh", rd, 32'h3);
    apb(1'b1, OFF_CTRL, 32'h21);
    guest(1'b1, 4'h9, 1'b0);
    chk("prio", 32'(task_priority), 32'h5);
    chk("flag", 32'(interrupt_enable_flag), 32'h1);
    guest(1'b0, 4'h0, 1'b0);
    chk("rdata", 32'(acc_rdata), 32'h9);
    apb(1'b0, OFF_SHADOW_BYTE, 32'h0);
    chk("shadow", rd, 32'h90);
    guest(1'b1, 4'h3, 1'b0);
    guest(1'b1, 4'h2, 1'b1);
    chk("flag", 32'(interrupt_enable_flag), 32'h0);
    apb(1'b0, OFF_EXIT_REASON, 32'h0);
    chk("reason", rd, 32'(REASON_THRESHOLD));
    apb(1'b1, OFF_STATUS, 32'h1);
    $display("shadow test done");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, OFF_CTRL, 32'h22 + 32'(i));
      guest(i[1], 4'hF, 1'b1);
      apb(1'b0, OFF_EXIT_REASON, 32'h0);
      chk("reason", rd, 32'(REASON_PRIO_ACCESS));
      apb(1'b0, OFF_SHADOW_BYTE, 32'h0);
      chk("shadow", rd, 32'h20);
      apb(1'b1, OFF_STATUS, 32'h1);
    end
    $display("exiting test done");
    ext_exit(32'h28);
    apb(1'b1, OFF_STATUS, 32'h1);
    ext_exit(32'h38);
    apb(1'b0, OFF_EXIT_INFO, 32'h0);
    chk("info", rd, 32'h8000_0045);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", rd, 32'h1);
    apb(1'b1, OFF_STATUS, 32'h1);
    host_vector <= 8'h1F;
    ext_exit(32'h38);
    apb(1'b0, OFF_EXIT_INFO, 32'h0);
    chk("info", rd, 32'h8000_001F);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", rd, 32'h5);
    apb(1'b1, OFF_STATUS, 32'h3);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    $display("interrupt test done");
    apb(1'b1, OFF_PAGE_LO, 32'h1234_5678);
    apb(1'b0, OFF_PAGE_LO, 32'h0);
    chk("page", rd, 32'h1234_5000);
    apb(1'b1, OFF_PAGE_HI, 32'h8765_4321);
    apb(1'b0, OFF_PAGE_HI, 32'h0);
    chk("page", rd, 32'h8765_4321);
    apb(1'b1, OFF_INTC_BASE_LO, 32'hABCD_EFFF);
    apb(1'b0, OFF_INTC_BASE_LO, 32'h0);
    chk("base", rd, 32'hABCD_E000);
    $display("pointer test done");
    @(posedge pclk);
    ce <= 1'b0;
    acc_valid <= 1'b1;
    acc_write <= 1'b1;
    acc_wdata <= 4'h7;
    @(posedge pclk);
    acc_valid <= 1'b0;
    @(posedge pclk);
    ce <= 1'b1;
    #1;
    chk("frozen", 32'(acc_done), 32'h0);
    chk("prio", 32'(task_priority), 32'h5);
    $display("enable test done");
    report_and_stop();
  end
  // watchdog well past the expected run
  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end
endmodule : test_priority_shadow_vm_exit_logic
`default_nettype wire
